// *** sim/cfs_src_model.sv ***
/*
  Model of the event sources and rising-event logic that feed the block.
  Assumes the bench commands source levels and rising requests on clk.
*/
`timescale 1ns/1ps
module cfs_src_model (
  input wire logic clk,
  input wire logic [8:0] lvl,
  input wire logic fire,
  output logic [8:0] pins,
  output logic rise_evt
);
  // **********
  // Sources
  // **********
  assign pins = lvl;
  always_ff @(posedge clk) begin
    rise_evt <= fire;
  end
endmodule : cfs_src_model

// *** sim/tb_top.sv ***
/*
  Self-checking bench: registers, falling sources, shutdown, interrupt.
  Assumes the design package and the source model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top
  import cfs_pkg::*;
;
  logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, fire = 0, probe = 0, rd_q = 0;
  logic [3:0] reg_addr = '0, wave = '0, polarity = '0, out_pin, out_oe;
  logic [7:0] reg_wdata = '0, reg_rdata, r;
  logic [8:0] lvl = 9'h1FF, pins;
  logic probe_q = 0;
  logic fall_evt, fall_db_evt, flag, irq, rise_evt;
  logic [23:0] exp_q[$];
  logic [23:0] e;
  logic [11:0] m, x;
  int n_mismatch = 0, n_compared = 0, seed = 435;

  cfs_falling_shutdown cfs_falling_shutdown_inst (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .numeric_oscillator_output(pins[7]),
    .third_pulse_modulator(pins[6]), .second_capture_unit(pins[5]),
    .first_capture_unit(pins[4]), .first_logic_cell(pins[3]), .comparator_two(pins[2]),
    .comparator_one(pins[1]), .pin_select_input(pins[0]), .second_logic_cell(pins[8]),
    .rise_evt(rise_evt), .wave(wave), .polarity(polarity), .fall_evt(fall_evt),
    .fall_db_evt(fall_db_evt), .shutdown_active_flag(flag), .out_pin(out_pin),
    .out_oe(out_oe), .irq(irq));
  cfs_src_model cfs_src_model_inst (.clk(clk), .lvl(lvl), .fire(fire), .pins(pins),
    .rise_evt(rise_evt));

  // **********
  // Clock and watcher
  // **********
  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    rd_q <= reg_rd;
    probe_q <= probe;
    if (rd_q) begin
      e = exp_q.pop_front();
      `CHK(reg_rdata, e[7:0])
    end
    if (probe != probe_q) begin
      e = exp_q.pop_front();
      `CHK({fall_evt, fall_db_evt, flag, irq, out_pin, out_oe} & e[23:12], e[11:0])
    end
  end

  // **********
  // Tasks
  // **********
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk) reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] v);
    exp_q.push_back({16'h0000, v});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk) reg_rd <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic chk(input logic [11:0] mk, input logic [11:0] v);
    exp_q.push_back({mk, v});
    probe <= ~probe;
    @(posedge clk);
  endtask : chk
  task automatic pulse_rise;
    fire <= 1'b1;
    tick(1);
    fire <= 1'b0;
    tick(3);
  endtask : pulse_rise
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // **********
  // Scenarios
  // **********
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    wave <= 4'($random(seed));
    polarity <= 4'($random(seed));
    r = 8'($random(seed));
    tick(12);
    sys_rst <= 1'b0;
    tick(1);
    rd(CFS_FSEL_OFS, 8'h00);
    rd(CFS_FMODE_OFS, 8'h00);
    rd(CFS_ASD0_OFS, 8'h00);
    rd(4'hF, 8'h00);
    wr(CFS_FMODE_OFS, r);
    rd(CFS_FMODE_OFS, r);
    wr(CFS_FMODE_OFS, 8'hFF);
    lvl[7:0] <= 8'h00;
    tick(4);
    chk(12'h800, 12'h000);
    tick(1);
    chk(12'h800, 12'h000);
    lvl[7:0] <= 8'hFF;
    tick(4);
    wr(CFS_FMODE_OFS, 8'h00);
    wr(CFS_DBF_OFS, 8'h02);
    for (int i = 0; i < 8; i++) begin
      wr(CFS_FSEL_OFS, 8'(1 << i));
      lvl[i] <= 1'b0;
      tick(3);
      chk(12'h800, 12'h800);
      tick(3);
      chk(12'h400, 12'h400);
      lvl[i] <= 1'b1;
      tick(8);
    end
    wr(CFS_PHASE_OFS, 8'h03);
    wr(CFS_FMODE_OFS, 8'h80);
    wr(CFS_FSEL_OFS, 8'h80);
    lvl[7] <= 1'b0;
    tick(5);
    chk(12'h800, 12'h000);
    tick(1);
    chk(12'h800, 12'h800);
    chk(12'h800, 12'h000);
    lvl[7] <= 1'b1;
    tick(4);
    wr(CFS_FSEL_OFS, 8'h00);
    wr(CFS_IRQ_EN_OFS, 8'h00);
    chk(12'h100, 12'h000);
    wr(CFS_IRQ_EN_OFS, 8'h01);
    chk(12'h100, 12'h100);
    wr(CFS_IRQ_CLR_OFS, 8'h01);
    chk(12'h100, 12'h000);
    wr(CFS_ASD1_OFS, 8'h02);
    wr(CFS_ASD0_OFS, 8'h38);
    lvl[1] <= 1'b0;
    tick(4);
    chk(12'h2FF, 12'h2AF);
    lvl[1] <= 1'b1;
    tick(4);
    rd(CFS_ASD0_OFS, 8'hB8);
    rd(CFS_IRQ_STAT_OFS, 8'h02);
    wr(CFS_ASD0_OFS, 8'h7B);
    rd(CFS_ASD0_OFS, 8'h78);
    chk(12'h2FF, 12'h0AF);
    pulse_rise();
    chk(12'h2FF, {4'h0, wave, 4'hF});
    lvl[1] <= 1'b0;
    tick(4);
    chk(12'h2FF, 12'h2AF);
    lvl[1] <= 1'b1;
    tick(4);
    chk(12'h2FF, 12'h0AF);
    pulse_rise();
    chk(12'h2FF, {4'h0, wave, 4'hF});
    wr(CFS_ASD0_OFS, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(CFS_ASD0_OFS, 8'h80 | 8'(c << 4) | 8'(c << 2));
      tick(2);
      m = (c == 1) ? 12'h20F : 12'h2FF;
      x = {4'h2, (c == 3) ? 4'hF : (c == 0) ? polarity : 4'h0, (c == 1) ? 4'h0 : 4'hF};
      chk(m, x);
      wr(CFS_ASD0_OFS, 8'h00);
      pulse_rise();
    end
    tick(2);
    give_verdict();
  end
endmodule : tb_top

// *** verilog/cfs_falling_shutdown.sv ***
/*
  Falling-event source select, phase and dead-band timing, and auto-shutdown
  state with output override for four outputs.
  Assumes event sources may be asynchronous; rise_evt, wave and polarity come
  from logic on clk.
*/
// Design decisions made here: the strobed register port and the placing of the registers.
// Operation
// - Eight select bits each let one source create falling events.
// - Select bits 7..4: oscillator, third modulator, capture two, capture one.
// - Select bits 3..0: first logic cell, comparator two, comparator one, pin.
// - Mode set: high-to-low transition makes falling event after phase delay.
// - Mode clear: low level makes an immediate falling event.
// - Mode bit ignored when select bit clear; no event then.
// - Select and mode registers reset to zero.
// - Shutdown status bit 7 reads one while in shutdown.
// - Bit 6 enables automatic restart after shutdown.
// - Bits 5-4 set B and D override: high, low, tri-state, inactive.
// - Bits 3-2 set A and C override with the same codes.
// - Bits 1-0 of shutdown control read zero, writes ignored.
// - Any enabled shutdown source low enters shutdown.
// - Complementary output delayed after falling event by six-bit count.
`timescale 1ns/1ps
module cfs_falling_shutdown
  import cfs_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic numeric_oscillator_output,
  input wire logic third_pulse_modulator,
  input wire logic second_capture_unit,
  input wire logic first_capture_unit,
  input wire logic first_logic_cell,
  input wire logic comparator_two,
  input wire logic comparator_one,
  input wire logic pin_select_input,
  input wire logic second_logic_cell,
  input wire logic rise_evt,
  input wire logic [3:0] wave,
  input wire logic [3:0] polarity,
  output logic fall_evt,
  output logic fall_db_evt,
  output logic shutdown_active_flag,
  output logic [3:0] out_pin,
  output logic [3:0] out_oe,
  output logic irq
);

  // ****************************************
  // Override decode
  // ****************************************
  function automatic logic [1:0] cfs_ovr(input logic [1:0] code, input logic pol,
                                         input logic wv, input logic sd);
    logic [1:0] r;
    r = {1'b1, wv};
    if (sd) begin
      case (code)
        CFS_OVR_HIGH: r = 2'b11;
        CFS_OVR_LOW: r = 2'b10;
        CFS_OVR_TRISTATE: r = 2'b00;
        default: r = {1'b1, pol};
      endcase
    end
    return r;
  endfunction : cfs_ovr

  cfs_state_t st;
  cfs_state_t next_st;
  logic [8:0] src_raw;
  logic [7:0] src_now;
  logic [3:0] sd_src;
  logic level_hit;
  logic edge_hit;
  logic sd_req;
  logic wr_asd0;
  logic [1:0] ovr;
  logic [1:0] irq_set;

  assign src_raw = {second_logic_cell, numeric_oscillator_output, third_pulse_modulator,
                    second_capture_unit, first_capture_unit, first_logic_cell,
                    comparator_two, comparator_one, pin_select_input};
  assign src_now = st.src_s2[7:0];
  assign sd_src = {st.src_s2[8], st.src_s2[2:0]};
  assign level_hit = |(st.regs.fsel & ~st.regs.fmode & ~src_now);
  assign edge_hit = |(st.regs.fsel & st.regs.fmode & st.src_s3 & ~src_now);
  assign sd_req = |(st.regs.sd_en & ~sd_src);
  assign wr_asd0 = reg_wr && reg_addr == CFS_ASD0_OFS;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    ovr = 2'b00;
    irq_set = 2'b00;
    next_st.src_s1 = src_raw;
    next_st.src_s2 = st.src_s1;
    next_st.src_s3 = src_now;
    next_st.fall_evt = level_hit;
    next_st.db_evt = 1'b0;
    next_st.rd_data = 8'h00;
    // Phase delay for edge-mode sources
    if (st.ph_busy) begin
      if (st.ph_cnt == CFS_CNT_RST) begin
        next_st.ph_busy = 1'b0;
        next_st.fall_evt = 1'b1;
      end else begin
        next_st.ph_cnt = st.ph_cnt - 6'h01;
      end
    end else if (edge_hit) begin
      next_st.ph_busy = 1'b1;
      next_st.ph_cnt = st.regs.phase;
    end
    // Falling dead-band for the complementary output
    if (st.db_busy) begin
      if (st.db_cnt == CFS_CNT_RST) begin
        next_st.db_busy = 1'b0;
        next_st.db_evt = 1'b1;
      end else begin
        next_st.db_cnt = st.db_cnt - 6'h01;
      end
    end else if (st.fall_evt) begin
      next_st.db_busy = 1'b1;
      next_st.db_cnt = st.regs.dbf;
    end
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        CFS_FSEL_OFS: next_st.regs.fsel = reg_wdata;
        CFS_FMODE_OFS: next_st.regs.fmode = reg_wdata;
        CFS_ASD0_OFS: begin
          next_st.regs.arsen = reg_wdata[CFS_ARSEN_BIT];
          next_st.regs.bd = reg_wdata[CFS_BD_LSB+:2];
          next_st.regs.ac = reg_wdata[CFS_AC_LSB+:2];
        end
        CFS_ASD1_OFS: next_st.regs.sd_en = reg_wdata[3:0];
        CFS_DBF_OFS: begin
          next_st.regs.dbf = reg_wdata[5:0];
          next_st.regs.db_chain = reg_wdata[CFS_DB_CHAIN_BIT];
        end
        CFS_PHASE_OFS: next_st.regs.phase = reg_wdata[5:0];
        CFS_IRQ_EN_OFS: next_st.regs.irq_en = reg_wdata[1:0];
        default: next_st.regs = st.regs;
      endcase
    end
    // Shutdown status: software write, auto-restart, then source request wins
    if (wr_asd0) begin
      next_st.sd_flag = reg_wdata[CFS_ASE_BIT];
    end
    if (st.regs.arsen && !sd_req) begin
      next_st.sd_flag = 1'b0;
    end
    if (sd_req) begin
      next_st.sd_flag = 1'b1;
    end
    next_st.sd_hold = st.sd_flag | (st.sd_hold & ~rise_evt);
    // Output override while shut down
    for (int i = 0; i < 4; i++) begin
      ovr = cfs_ovr((i % 2 == 1) ? st.regs.bd : st.regs.ac, polarity[i], wave[i],
                    st.sd_flag | st.sd_hold);
      next_st.out_oe[i] = ovr[1];
      next_st.out_pin[i] = ovr[0];
    end
    // Interrupt status: set wins over clear
    irq_set[CFS_IRQ_FALL_BIT] = next_st.fall_evt;
    irq_set[CFS_IRQ_SD_BIT] = sd_req & ~st.sd_flag;
    if (reg_wr && reg_addr == CFS_IRQ_CLR_OFS) begin
      next_st.irq_stat = st.irq_stat & ~reg_wdata[1:0];
    end
    next_st.irq_stat = next_st.irq_stat | irq_set;
    // Register reads, data in the following cycle
    if (reg_rd) begin
      case (reg_addr)
        CFS_FSEL_OFS: next_st.rd_data = st.regs.fsel;
        CFS_FMODE_OFS: next_st.rd_data = st.regs.fmode;
        CFS_ASD0_OFS: next_st.rd_data = {st.sd_flag, st.regs.arsen, st.regs.bd,
                                         st.regs.ac, 2'b00};
        CFS_ASD1_OFS: next_st.rd_data = {4'h0, st.regs.sd_en};
        CFS_DBF_OFS: next_st.rd_data = {1'b0, st.regs.db_chain, st.regs.dbf};
        CFS_PHASE_OFS: next_st.rd_data = {2'b00, st.regs.phase};
        CFS_IRQ_STAT_OFS: next_st.rd_data = {6'h00, st.irq_stat};
        CFS_IRQ_EN_OFS: next_st.rd_data = {6'h00, st.regs.irq_en};
        default: next_st.rd_data = 8'h00;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= CFS_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rd_data;
  assign fall_evt = st.fall_evt;
  assign fall_db_evt = st.db_evt;
  assign shutdown_active_flag = st.sd_flag;
  assign out_pin = st.out_pin;
  assign out_oe = st.out_oe;
  assign irq = |(st.irq_stat & st.regs.irq_en);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence edge_start_s;
    edge_hit && !st.ph_busy;
  endsequence

  sequence phase_end_s;
    st.ph_busy && st.ph_cnt == CFS_CNT_RST;
  endsequence

  reset_sel_a: assert property ($past(sys_rst) |-> st.regs.fsel == CFS_FSEL_RST
    && st.regs.fmode == CFS_FMODE_RST) else $error("select or mode not cleared");
  level_fall_a: assert property (level_hit |=> st.fall_evt)
    else $error("level source gave no falling event");
  edge_load_a: assert property (edge_start_s |=> st.ph_busy
    && st.ph_cnt == $past(st.regs.phase)) else $error("phase delay not loaded");
  edge_fire_a: assert property (phase_end_s |=> st.fall_evt && !st.ph_busy)
    else $error("phase delay end gave no event");
  none_sel_a: assert property (st.regs.fsel == 8'h00 && !st.ph_busy |=> !st.fall_evt)
    else $error("event from unselected source");
  sd_enter_a: assert property (sd_req |=> st.sd_flag ##0 shutdown_active_flag)
    else $error("shutdown not entered");
  no_restart_a: assert property (!st.regs.arsen && st.sd_flag && !wr_asd0 |=>
    st.sd_flag) else $error("status cleared without restart");
  auto_clr_a: assert property (st.regs.arsen && st.sd_flag && !sd_req && !wr_asd0
    |=> !st.sd_flag && st.sd_hold) else $error("auto-restart failed");
  bd_tri_a: assert property (st.sd_flag && st.regs.bd == CFS_OVR_TRISTATE |=>
    !out_oe[1] && !out_oe[3]) else $error("B and D not tri-stated");
  ac_high_a: assert property (st.sd_flag && st.regs.ac == CFS_OVR_HIGH |=>
    out_pin[0] && out_pin[2] && out_oe[0] && out_oe[2]) else $error("A and C not high");
  asd_low_a: assert property (reg_rd && reg_addr == CFS_ASD0_OFS |=>
    reg_rdata[1:0] == 2'b00) else $error("low shutdown bits not zero");
  asd_flag_a: assert property (reg_rd && reg_addr == CFS_ASD0_OFS |=>
    reg_rdata[7] == $past(st.sd_flag)) else $error("status bit misread");
  db_load_a: assert property (st.fall_evt && !st.db_busy |=> st.db_busy
    && st.db_cnt == $past(st.regs.dbf)) else $error("dead-band not loaded");

endmodule : cfs_falling_shutdown

// *** verilog/cfs_pkg.sv ***
/*
  Package for the falling-source select and auto-shutdown block: register
  offsets, field positions, reset values, override codes and state layout.
  Assumes an 8-bit register port with a 4-bit register index.
*/
package cfs_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int CFS_AW = 4;
  localparam int CFS_DW = 8;
  localparam logic [3:0] CFS_FSEL_OFS = 4'h0;
  localparam logic [3:0] CFS_FMODE_OFS = 4'h1;
  localparam logic [3:0] CFS_ASD0_OFS = 4'h2;
  localparam logic [3:0] CFS_ASD1_OFS = 4'h3;
  localparam logic [3:0] CFS_DBF_OFS = 4'h4;
  localparam logic [3:0] CFS_PHASE_OFS = 4'h5;
  localparam logic [3:0] CFS_IRQ_STAT_OFS = 4'h6;
  localparam logic [3:0] CFS_IRQ_EN_OFS = 4'h7;
  localparam logic [3:0] CFS_IRQ_CLR_OFS = 4'h8;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CFS_ASE_BIT = 7;
  localparam int CFS_ARSEN_BIT = 6;
  localparam int CFS_BD_LSB = 4;
  localparam int CFS_AC_LSB = 2;
  localparam int CFS_DB_CHAIN_BIT = 6;
  localparam int CFS_IRQ_FALL_BIT = 0;
  localparam int CFS_IRQ_SD_BIT = 1;
  localparam logic [7:0] CFS_FSEL_RST = 8'h00;
  localparam logic [7:0] CFS_FMODE_RST = 8'h00;
  localparam logic [5:0] CFS_CNT_RST = 6'h00;

  typedef enum logic [1:0] {
    CFS_OVR_INACTIVE = 2'b00,
    CFS_OVR_TRISTATE = 2'b01,
    CFS_OVR_LOW = 2'b10,
    CFS_OVR_HIGH = 2'b11
  } cfs_ovr_t;

  typedef struct packed {
    logic [7:0] fsel;
    logic [7:0] fmode;
    logic arsen;
    logic [1:0] bd;
    logic [1:0] ac;
    logic [3:0] sd_en;
    logic [5:0] dbf;
    logic db_chain;
    logic [5:0] phase;
    logic [1:0] irq_en;
  } cfs_regs_t;

  typedef struct packed {
    cfs_regs_t regs;
    logic sd_flag;
    logic sd_hold;
    logic [1:0] irq_stat;
    logic [8:0] src_s1;
    logic [8:0] src_s2;
    logic [7:0] src_s3;
    logic ph_busy;
    logic [5:0] ph_cnt;
    logic db_busy;
    logic [5:0] db_cnt;
    logic fall_evt;
    logic db_evt;
    logic [3:0] out_pin;
    logic [3:0] out_oe;
    logic [7:0] rd_data;
  } cfs_state_t;

  localparam cfs_state_t CFS_STATE_RST = '0;

endpackage : cfs_pkg
